// ===== agu_pkg.sv
// constants and types for the address generation unit
package agu_pkg;
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [15:0] VECTOR_BASE = 16'h0040;
    localparam logic [15:0] SHORT_BASE = 16'hFE00;
    localparam logic [7:0] SHORT_SFR_LIMIT = 8'h20;
    localparam logic [15:0] SFR_BASE = 16'hFF00;
    localparam int TABLE_LO = 1;
    localparam int TABLE_HI = 5;
    localparam int SHORT_HI_BIT = 8;
    localparam int SIGN_BIT = 7;

    // program counter source
    typedef enum logic [2:0] {
        PC_HOLD,
        PC_SEQ,
        PC_REL,
        PC_IMM,
        PC_TABLE,
        PC_ACC
    } pc_op_t;

    // operand addressing method
    typedef enum logic [2:0] {
        EA_NONE,
        EA_DIRECT,
        EA_SHORT,
        EA_SFR,
        EA_INDIRECT,
        EA_BASED,
        EA_STACK
    } ea_op_t;
endpackage

// ===== agu_regsel.sv
// general register and register pair selector
`timescale 1ns/1ps
module agu_regsel
    import agu_pkg::*;
(
    input wire logic [8*BYTE_W-1:0] regs_i,
    input wire logic [2:0] reg_sel_i,
    input wire logic [1:0] pair_sel_i,
    output logic [BYTE_W-1:0] reg_val_o,
    output logic [2*BYTE_W-1:0] pair_val_o
);
    // pair n is high register 2n+1 over low register 2n
    always_comb
    begin
        reg_val_o = regs_i[reg_sel_i*BYTE_W +: BYTE_W];
        pair_val_o = regs_i[pair_sel_i*2*BYTE_W +: 2*BYTE_W];
    end
endmodule

// ===== address_generation_unit.sv
// program counter and effective address generation
`timescale 1ns/1ps
// Overview of operation
// - sequential fetch adds the instruction byte length to the program counter
// - relative target is next address plus sign-extended 8-bit displacement
// - relative target serves unconditional and all conditional relative branches
// - absolute call and branch load the 16-bit immediate into the counter
// - table call reads entry selected by bits 1 to 5 in 40H-7FH
// - register branch loads the accumulator pair into the counter
// - direct addressing uses the 16-bit immediate as the address
// - short direct: bit 8 set for 00H-1FH, clear for 20H-FFH
// - short direct window spans FE20H to FF1FH
// - special register addressing maps the 8-bit immediate into FF00H-FFFFH
// - 3-bit field picks one of eight registers; pairs one of four
// - register indirect uses the chosen index or base pair as address
// - based adds zero-extended offset to the base pair, carry dropped
// - stack accesses use the stack pointer as address
module address_generation_unit
    import agu_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // program counter control
    input wire logic STEP_I,
    input wire pc_op_t PC_OP_I,
    input wire logic [2:0] INSTR_LEN_I,
    input wire logic [BYTE_W-1:0] OPCODE_I,
    input wire logic [ADDR_W-1:0] IMM16_I,
    input wire logic [BYTE_W-1:0] IMM8_I,
    input wire logic [ADDR_W-1:0] TABLE_DATA_I,
    // operand control
    input wire ea_op_t EA_OP_I,
    input wire logic INDIRECT_BASE_I,
    input wire logic [2:0] REG_SEL_I,
    input wire logic [1:0] PAIR_SEL_I,
    input wire logic [8*BYTE_W-1:0] REGS_I,
    input wire logic [ADDR_W-1:0] SP_I,
    // results
    output logic [ADDR_W-1:0] PC_O,
    output logic [ADDR_W-1:0] TABLE_ADDR_O,
    output logic [ADDR_W-1:0] EA_O,
    output logic EA_VALID_O,
    output logic [BYTE_W-1:0] REG_VAL_O,
    output logic [2*BYTE_W-1:0] PAIR_VAL_O
);
    localparam logic [1:0] PAIR_ACC = 2'h0;
    localparam logic [1:0] PAIR_INDEX = 2'h2;
    localparam logic [1:0] PAIR_BASE = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] table_addr;
        logic [ADDR_W-1:0] ea;
        logic ea_valid;
        logic [BYTE_W-1:0] reg_val;
        logic [2*BYTE_W-1:0] pair_val;
        logic armed;
    } state_t;

    state_t st;
    state_t next_st;
    logic [1:0] rst_sync;
    logic rst_n;
    logic [BYTE_W-1:0] sel_reg;
    logic [2*BYTE_W-1:0] sel_pair;
    logic [ADDR_W-1:0] seq_pc;

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    agu_regsel u_regsel (
        .regs_i(REGS_I),
        .reg_sel_i(REG_SEL_I),
        .pair_sel_i(PAIR_SEL_I),
        .reg_val_o(sel_reg),
        .pair_val_o(sel_pair)
    );

    function automatic logic [2*BYTE_W-1:0] pair_of(input logic [8*BYTE_W-1:0] r,
                                                   input logic [1:0] n);
        pair_of = r[n*2*BYTE_W +: 2*BYTE_W];
    endfunction

    // address of the following instruction
    assign seq_pc = ADDR_W'(st.pc + ADDR_W'(INSTR_LEN_I));

    always_comb
    begin
        next_st = st;
        // low only until the first update after reset has been registered
        next_st.armed = 1'b1;
        next_st.reg_val = sel_reg;
        next_st.pair_val = sel_pair;
        next_st.table_addr = VECTOR_BASE
            | ADDR_W'({OPCODE_I[TABLE_HI:TABLE_LO], 1'b0});
        if (STEP_I)
        begin
            case (PC_OP_I)
                PC_SEQ: next_st.pc = seq_pc;
                PC_REL: next_st.pc = ADDR_W'(seq_pc
                    + {{(ADDR_W-BYTE_W){IMM8_I[SIGN_BIT]}}, IMM8_I});
                PC_IMM: next_st.pc = IMM16_I;
                PC_TABLE: next_st.pc = TABLE_DATA_I;
                PC_ACC: next_st.pc = pair_of(REGS_I, PAIR_ACC);
                default: next_st.pc = st.pc;
            endcase
        end
        next_st.ea_valid = 1'b1;
        case (EA_OP_I)
            EA_DIRECT: next_st.ea = IMM16_I;
            EA_SHORT:
            begin
                next_st.ea = SHORT_BASE | ADDR_W'(IMM8_I);
                next_st.ea[SHORT_HI_BIT] = (IMM8_I < SHORT_SFR_LIMIT);
            end
            EA_SFR: next_st.ea = SFR_BASE | ADDR_W'(IMM8_I);
            EA_INDIRECT: next_st.ea = pair_of(REGS_I,
                INDIRECT_BASE_I ? PAIR_BASE : PAIR_INDEX);
            EA_BASED: next_st.ea = ADDR_W'(pair_of(REGS_I, PAIR_BASE)
                + ADDR_W'(IMM8_I));
            EA_STACK: next_st.ea = SP_I;
            default:
            begin
                next_st.ea = st.ea;
                next_st.ea_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.pc <= RESET_PC;
        end
        else
            st <= next_st;
    end

    assign PC_O = st.pc;
    assign TABLE_ADDR_O = st.table_addr;
    assign EA_O = st.ea;
    assign EA_VALID_O = st.ea_valid;
    assign REG_VAL_O = st.reg_val;
    assign PAIR_VAL_O = st.pair_val;

    a_pc_sequential: assert property (@(posedge CLK_I) disable iff (!rst_n)
        STEP_I && PC_OP_I == PC_SEQ |=> PC_O == ADDR_W'($past(PC_O) + $past(INSTR_LEN_I)))
        else $error("sequential pc step wrong");
    a_pc_relative: assert property (@(posedge CLK_I) disable iff (!rst_n)
        STEP_I && PC_OP_I == PC_REL |=> PC_O == ADDR_W'($past(PC_O) + $past(INSTR_LEN_I)
            + {{8{$past(IMM8_I[7])}}, $past(IMM8_I)}))
        else $error("relative target wrong");
    a_pc_hold_idle: assert property (@(posedge CLK_I) disable iff (!rst_n)
        !STEP_I |=> $stable(PC_O))
        else $error("pc moved without step");
    a_pc_immediate: assert property (@(posedge CLK_I) disable iff (!rst_n)
        STEP_I && PC_OP_I == PC_IMM |=> PC_O == $past(IMM16_I))
        else $error("immediate branch wrong");
    a_table_entry: assert property (@(posedge CLK_I) disable iff (!rst_n)
        st.armed |=> TABLE_ADDR_O >= 16'h0040 && TABLE_ADDR_O <= 16'h007E
            && TABLE_ADDR_O[0] == 1'b0
            && TABLE_ADDR_O[5:1] == $past(OPCODE_I[5:1]))
        else $error("table entry address wrong");
    a_pc_acc: assert property (@(posedge CLK_I) disable iff (!rst_n)
        STEP_I && PC_OP_I == PC_ACC |=> PC_O == $past(REGS_I[15:0]))
        else $error("register branch wrong");
    a_ea_direct: assert property (@(posedge CLK_I) disable iff (!rst_n)
        EA_OP_I == EA_DIRECT |=> EA_O == $past(IMM16_I) && EA_VALID_O)
        else $error("direct address wrong");
    a_short_window: assert property (@(posedge CLK_I) disable iff (!rst_n)
        EA_OP_I == EA_SHORT |=> EA_O >= 16'hFE20 && EA_O <= 16'hFF1F
            && EA_O[7:0] == $past(IMM8_I))
        else $error("short direct address wrong");
    a_sfr_space: assert property (@(posedge CLK_I) disable iff (!rst_n)
        EA_OP_I == EA_SFR |=> EA_O == {8'hFF, $past(IMM8_I)})
        else $error("sfr address wrong");
    a_based_sum: assert property (@(posedge CLK_I) disable iff (!rst_n)
        EA_OP_I == EA_BASED |=> EA_O == ADDR_W'($past(REGS_I[63:48]) + $past(IMM8_I)))
        else $error("based address wrong");
    a_stack_sp: assert property (@(posedge CLK_I) disable iff (!rst_n)
        EA_OP_I == EA_STACK |=> EA_O == $past(SP_I))
        else $error("stack address wrong");
    a_reg_select: assert property (@(posedge CLK_I) disable iff (!rst_n)
        st.armed |=> REG_VAL_O == $past(REGS_I[REG_SEL_I*8 +: 8]))
        else $error("register select wrong");
    a_pair_select: assert property (@(posedge CLK_I) disable iff (!rst_n)
        st.armed |=> PAIR_VAL_O[7:0] == $past(REGS_I[PAIR_SEL_I*16 +: 8])
            && PAIR_VAL_O[15:8] == $past(REGS_I[PAIR_SEL_I*16+8 +: 8]))
        else $error("pair select wrong");
    a_short_ram: assert property (@(posedge CLK_I) disable iff (!rst_n)
        EA_OP_I == EA_SHORT && IMM8_I >= 8'h20 |=> EA_O[15:8] == 8'hFE)
        else $error("short direct ram page wrong");
    a_short_sfr: assert property (@(posedge CLK_I) disable iff (!rst_n)
        EA_OP_I == EA_SHORT && IMM8_I <= 8'h1F |=> EA_O[15:8] == 8'hFF)
        else $error("short direct register page wrong");
    a_indirect_pair: assert property (@(posedge CLK_I) disable iff (!rst_n)
        EA_OP_I == EA_INDIRECT |=> EA_O == ($past(INDIRECT_BASE_I)
            ? $past(REGS_I[63:48]) : $past(REGS_I[47:32])))
        else $error("indirect address wrong");
    a_pc_table: assert property (@(posedge CLK_I) disable iff (!rst_n)
        STEP_I && PC_OP_I == PC_TABLE |=> PC_O == $past(TABLE_DATA_I))
        else $error("table branch wrong");
    a_pc_hold_op: assert property (@(posedge CLK_I) disable iff (!rst_n)
        STEP_I && PC_OP_I == PC_HOLD |=> $stable(PC_O))
        else $error("pc moved on hold");
    a_ea_held_idle: assert property (@(posedge CLK_I) disable iff (!rst_n)
        st.armed && EA_OP_I == EA_NONE |=> !EA_VALID_O && $stable(EA_O))
        else $error("idle address not held");
    a_ea_valid_set: assert property (@(posedge CLK_I) disable iff (!rst_n)
        EA_OP_I inside {EA_DIRECT, EA_SHORT, EA_SFR, EA_INDIRECT, EA_BASED, EA_STACK}
            |=> EA_VALID_O)
        else $error("address valid missing");
endmodule

// ===== vector_table_model.sv
// vector table memory answering the unit's table lookups
`timescale 1ns/1ps
module vector_table_model
    import agu_pkg::*;
(
    // lookup
    input wire logic [ADDR_W-1:0] addr_i,
    // stored vector word
    output logic [ADDR_W-1:0] data_o
);
    // each byte a fixed function of its address, low byte at the even one
    always_comb
    begin
        data_o[7:0] = {addr_i[7:1], 1'b0} ^ 8'h3C;
        data_o[15:8] = {addr_i[7:1], 1'b1} ^ 8'h3C;
    end
endmodule

// ===== address_generation_unit_bench.sv
// self-checking bench for the address generation unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module address_generation_unit_bench;
    import agu_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, step = 1'b0, ind_base = 1'b0, ea_v;
    pc_op_t pc_op = PC_HOLD;
    ea_op_t ea_op = EA_NONE;
    logic [2:0] len = 3'h0, rsel = 3'h0;
    logic [1:0] psel = 2'h0;
    logic [7:0] opc = 8'h00, imm8 = 8'h00, rval;
    logic [15:0] imm16 = 16'h0000, sp = 16'h0000, pc, taddr, tdata, ea, pair;
    logic [63:0] regs = 64'hFFF0665544332211;
    int mismatches = 0, n_compared = 0, cycles = 0;
    always #2.5 clk = ~clk;
    address_generation_unit u_address_generation_unit (.CLK_I(clk), .ARST_N_I(arst_n),
        .STEP_I(step), .PC_OP_I(pc_op), .INSTR_LEN_I(len), .OPCODE_I(opc),
        .IMM16_I(imm16), .IMM8_I(imm8), .TABLE_DATA_I(tdata), .EA_OP_I(ea_op),
        .INDIRECT_BASE_I(ind_base), .REG_SEL_I(rsel), .PAIR_SEL_I(psel), .REGS_I(regs),
        .SP_I(sp), .PC_O(pc), .TABLE_ADDR_O(taddr), .EA_O(ea), .EA_VALID_O(ea_v),
        .REG_VAL_O(rval), .PAIR_VAL_O(pair));
    vector_table_model u_vector_table_model (.addr_i(taddr), .data_o(tdata));
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one request taken at a rising edge, result seen at the next falling edge
    task automatic run(input logic s, input pc_op_t p, input ea_op_t e);
        @(negedge clk);
        step = s;
        pc_op = p;
        ea_op = e;
        @(negedge clk);
        step = 1'b0;
        ea_op = EA_NONE;
    endtask
    task automatic ea_chk(input ea_op_t e, input logic [15:0] exp, input string n);
        run(1'b0, PC_HOLD, e);
        `CHK(n, exp, ea)
        `CHK("ea valid", 1'b1, ea_v)
    endtask
    task automatic t_seq;
        len = 3'h3;
        run(1'b1, PC_SEQ, EA_NONE);
        `CHK("pc seq3", 16'h0003, pc)
        len = 3'h1;
        run(1'b1, PC_SEQ, EA_NONE);
        `CHK("pc seq1", 16'h0004, pc)
        run(1'b0, PC_SEQ, EA_NONE);
        `CHK("pc idle", 16'h0004, pc)
        run(1'b1, PC_HOLD, EA_NONE);
        `CHK("pc hold op", 16'h0004, pc)
    endtask
    task automatic t_rel;
        len = 3'h2;
        imm8 = 8'h80;
        run(1'b1, PC_REL, EA_NONE);
        `CHK("pc rel back", 16'hFF86, pc)
        imm8 = 8'h7F;
        run(1'b1, PC_REL, EA_NONE);
        `CHK("pc rel fwd", 16'h0007, pc)
    endtask
    task automatic t_br;
        imm16 = 16'hBEEF;
        run(1'b1, PC_IMM, EA_NONE);
        `CHK("pc imm", 16'hBEEF, pc)
        run(1'b1, PC_ACC, EA_NONE);
        `CHK("pc acc", 16'h2211, pc)
    endtask
    task automatic t_tab;
        opc = 8'hC1;
        run(1'b0, PC_HOLD, EA_NONE);
        `CHK("table lo", 16'h0040, taddr)
        opc = 8'hFF;
        run(1'b0, PC_HOLD, EA_NONE);
        `CHK("table hi", 16'h007E, taddr)
        run(1'b1, PC_TABLE, EA_NONE);
        `CHK("pc table", {8'h7F ^ 8'h3C, 8'h7E ^ 8'h3C}, pc)
    endtask
    task automatic t_ea;
        imm16 = 16'h1234;
        ea_chk(EA_DIRECT, 16'h1234, "direct");
        imm8 = 8'h1F;
        ea_chk(EA_SHORT, 16'hFF1F, "short sfr");
        imm8 = 8'h20;
        ea_chk(EA_SHORT, 16'hFE20, "short ram");
        imm8 = 8'hFE;
        ea_chk(EA_SHORT, 16'hFEFE, "short word");
        imm8 = 8'hFF;
        ea_chk(EA_SFR, 16'hFFFF, "sfr");
        ea_chk(EA_INDIRECT, 16'h6655, "index pair");
        ind_base = 1'b1;
        ea_chk(EA_INDIRECT, 16'hFFF0, "base pair");
        imm8 = 8'h20;
        ea_chk(EA_BASED, 16'h0010, "based wrap");
        sp = 16'hFEE0;
        ea_chk(EA_STACK, 16'hFEE0, "stack");
        run(1'b0, PC_HOLD, EA_NONE);
        `CHK("ea held", 16'hFEE0, ea)
        `CHK("ea idle", 1'b0, ea_v)
    endtask
    task automatic t_reg;
        for (int i = 0; i < 8; i++)
        begin
            rsel = i[2:0];
            psel = i[1:0];
            run(1'b0, PC_HOLD, EA_NONE);
            `CHK("reg", regs[8*i +: 8], rval)
            `CHK("pair", regs[16*(i%4) +: 16], pair)
        end
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("pc reset", RESET_PC, pc)
        t_seq;
        t_rel;
        t_br;
        t_tab;
        t_ea;
        t_reg;
        tally_and_finish;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 500)
        begin
            mismatches++;
            tally_and_finish;
        end
    end
endmodule
